// >>> dv/tb_branch_skip_compare_exec.sv
// Self-checking testbench for the control-flow execute block.
module tb_branch_skip_compare_exec
	import flow_exec_pkg::*;
();
	timeunit 1ns;
	timeprecision 1ns;
	logic        i_clk_sys, i_reset_n, i_valid, i_next_two_word;
	op_t         i_op;
	logic [2:0]  i_bit_sel;
	logic [6:0]  i_offset;
	logic [7:0]  i_immediate, i_dest_value, i_source_register, i_io_data;
	logic [15:0] i_pointer, o_pc, o_push_addr, pc_exp;
	logic [4:0]  i_io_port_addr;
	logic [IO_ADDR_W-1:0] o_io_addr;
	logic [7:0]  o_status_flags_reg;
	logic        o_push_valid;
	int          fails, tests_run;

	branch_skip_compare_exec u_branch_skip_compare_exec (
		.i_clk_sys          (i_clk_sys),
		.i_reset_n          (i_reset_n),
		.i_valid            (i_valid),
		.i_op               (i_op),
		.i_bit_sel          (i_bit_sel),
		.i_offset           (i_offset),
		.i_immediate        (i_immediate),
		.i_next_two_word    (i_next_two_word),
		.i_dest_value       (i_dest_value),
		.i_source_register  (i_source_register),
		.i_pointer          (i_pointer),
		.o_io_addr          (o_io_addr),
		.i_io_port_addr     (i_io_port_addr),
		.i_io_data          (i_io_data),
		.o_pc               (o_pc),
		.o_status_flags_reg (o_status_flags_reg),
		.o_push_valid       (o_push_valid),
		.o_push_addr        (o_push_addr)
	);

	initial begin
		i_clk_sys = 1'b0;
		forever #10 i_clk_sys = ~i_clk_sys;
	end

	task automatic chk(input string name, input logic [15:0] exp,
			input logic [15:0] got);
		tests_run++;
		if (got !== exp) begin
			$display("mismatch %s expected %h seen %h", name, exp, got);
			fails++;
		end
	endtask : chk

	// Presents one instruction; back-to-back calls keep valid high.
	task automatic step(input op_t op, input logic [15:0] delta);
		i_op = op;
		i_valid = 1'b1;
		pc_exp = pc_exp + delta;
		@(negedge i_clk_sys);
		chk("pc", pc_exp, o_pc);
	endtask : step

	task automatic t_call();
		logic [15:0] ret;
		ret = pc_exp + 16'h0001;
		i_pointer = 16'h0200;
		step(OP_POINTER_CALL, 16'h0200 - pc_exp);
		chk("push_valid", 16'h0001, {15'h0000, o_push_valid});
		chk("push_addr", ret, o_push_addr);
		step(OP_NOP, 16'h0001);
		chk("push_valid", 16'h0000, {15'h0000, o_push_valid});
	endtask : t_call

	task automatic t_compare_skip_equal();
		i_dest_value = 8'h5a;
		i_source_register = 8'h5a;
		i_next_two_word = 1'b0;
		step(OP_COMPARE_SKIP_EQ, 16'h0002);
		i_next_two_word = 1'b1;
		step(OP_COMPARE_SKIP_EQ, 16'h0003);
		i_source_register = 8'h5b;
		step(OP_COMPARE_SKIP_EQ, 16'h0001);
	endtask : t_compare_skip_equal

	// Last entry leaves C, N and S set for the branch scenario.
	task automatic t_cpi();
		logic [7:0] d [3] = '{8'h55, 8'h80, 8'h10};
		logic [7:0] k [3] = '{8'h55, 8'h01, 8'h20};
		logic [7:0] f [3] = '{8'h02, 8'h38, 8'h15};
		for (int n = 0; n < 3; n++) begin
			i_dest_value = d[n];
			i_immediate = k[n];
			step(OP_COMPARE_IMMEDIATE, 16'h0001);
			chk("flags", 16'(f[n]), 16'(o_status_flags_reg));
		end
	endtask : t_cpi

	task automatic t_skip_reg_bit_clear();
		i_source_register = 8'h04;
		i_next_two_word = 1'b0;
		i_bit_sel = 3'h2;
		step(OP_SKIP_REG_BIT_CLR, 16'h0001);
		i_bit_sel = 3'h3;
		step(OP_SKIP_REG_BIT_CLR, 16'h0002);
		i_next_two_word = 1'b1;
		step(OP_SKIP_REG_BIT_CLR, 16'h0003);
	endtask : t_skip_reg_bit_clear

	task automatic t_io();
		i_io_port_addr = 5'h1f;
		i_io_data = 8'h80;
		i_bit_sel = 3'h7;
		i_next_two_word = 1'b0;
		step(OP_SKIP_IO_BIT_SET, 16'h0002);
		chk("io_addr", 16'h001f, {11'h000, o_io_addr});
		step(OP_SKIP_IO_BIT_CLR, 16'h0001);
		i_io_data = 8'h7f;
		i_next_two_word = 1'b1;
		i_io_port_addr = 5'h0a;
		step(OP_SKIP_IO_BIT_CLR, 16'h0003);
		chk("io_addr", 16'h000a, {11'h000, o_io_addr});
		step(OP_SKIP_IO_BIT_SET, 16'h0001);
		chk("flags", 16'h0015, {8'h00, o_status_flags_reg});
	endtask : t_io

	task automatic t_branch();
		i_bit_sel = 3'h0;
		i_offset = 7'h03;
		step(OP_BRANCH_FLAG_SET, 16'h0004);
		step(OP_BRANCH_FLAG_CLR, 16'h0001);
		i_offset = 7'h7e;
		step(OP_BRANCH_FLAG_SET, 16'hffff);
		i_offset = 7'h7f;
		step(OP_BRANCH_FLAG_SET, 16'h0000);
		i_bit_sel = 3'h1;
		i_offset = 7'h05;
		step(OP_BRANCH_FLAG_CLR, 16'h0006);
		step(OP_BRANCH_FLAG_SET, 16'h0001);
		chk("flags", 16'h0015, {8'h00, o_status_flags_reg});
	endtask : t_branch

	// With valid low nothing executes, so the counter must hold.
	task automatic t_hold();
		i_valid = 1'b0;
		repeat (3) @(negedge i_clk_sys);
		chk("pc", pc_exp, o_pc);
		step(OP_NOP, 16'h0001);
	endtask : t_hold

	task automatic summarize();
		$display("comparisons %0d mismatches %0d", tests_run, fails);
		if (fails == 0 && tests_run > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask : summarize

	initial begin
		{i_reset_n, i_valid, i_next_two_word, i_bit_sel, i_offset} = '0;
		{i_immediate, i_dest_value, i_source_register, i_io_data} = '0;
		{i_pointer, i_io_port_addr} = '0;
		i_op = OP_NOP;
		fails = 0;
		tests_run = 0;
		pc_exp = RESET_PC;
		repeat (16) @(negedge i_clk_sys);
		chk("pc", RESET_PC, o_pc);
		chk("flags", {8'h00, RESET_FLAGS}, {8'h00, o_status_flags_reg});
		chk("push_valid", 16'h0000, {15'h0000, o_push_valid});
		chk("push_addr", RESET_PC, o_push_addr);
		i_reset_n = 1'b1;
		t_compare_skip_equal();
		t_call();
		t_cpi();
		t_skip_reg_bit_clear();
		t_io();
		t_branch();
		t_hold();
		summarize();
	end

	initial begin
		#40000;
		fails++;
		summarize();
	end
endmodule : tb_branch_skip_compare_exec

// >>> include/flow_exec_pkg.sv
// Package of encodings and constants for the control-flow execute block.
package flow_exec_pkg;
	localparam int PC_W = 16;
	localparam int DATA_W = 8;
	localparam int IO_ADDR_W = 5;
	localparam logic [15:0] RESET_PC = 16'h0000;
	localparam logic [7:0] RESET_FLAGS = 8'h00;
	localparam logic [15:0] STEP_ONE = 16'h0001;
	localparam logic [15:0] SKIP_ONE_WORD = 16'h0002;
	localparam logic [15:0] SKIP_TWO_WORD = 16'h0003;
	localparam int FLAG_C = 0;
	localparam int FLAG_Z = 1;
	localparam int FLAG_N = 2;
	localparam int FLAG_V = 3;
	localparam int FLAG_S = 4;
	localparam int FLAG_H = 5;

	// Operation codes after fetch has decoded the instruction word.
	typedef enum logic [3:0] {
		OP_NOP               = 4'h0,
		OP_POINTER_CALL      = 4'h1,
		OP_COMPARE_SKIP_EQ   = 4'h2,
		OP_COMPARE_IMMEDIATE = 4'h3,
		OP_SKIP_REG_BIT_CLR  = 4'h4,
		OP_SKIP_IO_BIT_SET   = 4'h5,
		OP_SKIP_IO_BIT_CLR   = 4'h6,
		OP_BRANCH_FLAG_SET   = 4'h7,
		OP_BRANCH_FLAG_CLR   = 4'h8
	} op_t;
endpackage : flow_exec_pkg

// >>> rtl/branch_skip_compare_exec.sv
// Execute stage for calls through a pointer, compares, skips and branches.
module branch_skip_compare_exec
	import flow_exec_pkg::*;
(
	// Clock and reset
	input  wire logic                 i_clk_sys,
	input  wire logic                 i_reset_n,
	// Decoded instruction
	input  wire logic                 i_valid,
	input  wire flow_exec_pkg::op_t   i_op,
	input  wire logic [2:0]           i_bit_sel,
	input  wire logic [6:0]           i_offset,
	input  wire logic [7:0]           i_immediate,
	input  wire logic                 i_next_two_word,
	// Register file operands
	input  wire logic [7:0]           i_dest_value,
	input  wire logic [7:0]           i_source_register,
	input  wire logic [15:0]          i_pointer,
	// I/O space
	output logic [flow_exec_pkg::IO_ADDR_W-1:0] o_io_addr,
	input  wire logic [4:0]           i_io_port_addr,
	input  wire logic [7:0]           i_io_data,
	// Results
	output logic [15:0]               o_pc,
	output logic [7:0]                o_status_flags_reg,
	output logic                      o_push_valid,
	output logic [15:0]               o_push_addr
);
	import flow_exec_pkg::*;

	logic [15:0] pc;
	logic [7:0]  status_flags_reg;
	logic        push_valid;
	logic [15:0] push_addr;
	wire logic [15:0] next_pc;
	wire logic [15:0] return_pc;
	wire logic [8:0]  diff;
	wire logic [4:0]  half_diff;
	wire logic        is_ptr;
	wire logic        is_cmpi;
	wire logic        is_skip;
	wire logic        is_branch;
	wire logic        sel_flag;
	wire logic [7:0]  next_flags;

	function automatic logic pick_bit(input logic [7:0] v,
		input logic [2:0] b);
		pick_bit = v[b];
	endfunction : pick_bit

	assign o_io_addr = i_io_port_addr;
	assign is_ptr = i_valid && (i_op == OP_POINTER_CALL);
	assign is_cmpi = i_valid && (i_op == OP_COMPARE_IMMEDIATE);
	assign sel_flag = pick_bit(status_flags_reg, i_bit_sel);
	assign is_skip = i_valid && (
		((i_op == OP_COMPARE_SKIP_EQ)
			&& (i_dest_value == i_source_register))
		|| ((i_op == OP_SKIP_REG_BIT_CLR)
			&& !pick_bit(i_source_register, i_bit_sel))
		|| ((i_op == OP_SKIP_IO_BIT_SET)
			&& pick_bit(i_io_data, i_bit_sel))
		|| ((i_op == OP_SKIP_IO_BIT_CLR)
			&& !pick_bit(i_io_data, i_bit_sel)));
	assign is_branch = i_valid && (
		((i_op == OP_BRANCH_FLAG_SET) && sel_flag)
		|| ((i_op == OP_BRANCH_FLAG_CLR) && !sel_flag));

	// Subtraction only feeds the flags; no register write path exists.
	assign diff = {1'b0, i_dest_value} - {1'b0, i_immediate};
	assign half_diff = {1'b0, i_dest_value[3:0]}
		- {1'b0, i_immediate[3:0]};
	assign next_flags = {
		status_flags_reg[7:6],
		half_diff[4],
		diff[7] ^ ((i_dest_value[7] & ~i_immediate[7] & ~diff[7])
			| (~i_dest_value[7] & i_immediate[7] & diff[7])),
		(i_dest_value[7] & ~i_immediate[7] & ~diff[7])
			| (~i_dest_value[7] & i_immediate[7] & diff[7]),
		diff[7],
		diff[7:0] == 8'h00,
		diff[8]};

	pc_next_calc u_pc_next_calc (
		.i_pc            (pc),
		.i_take_ptr      (is_ptr),
		.i_ptr           (i_pointer),
		.i_take_branch   (is_branch),
		.i_offset        (i_offset),
		.i_skip          (is_skip),
		.i_next_two_word (i_next_two_word),
		.o_next_pc       (next_pc),
		.o_return_pc     (return_pc)
	);

	// Without a valid instruction the counter holds.
	always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
		if (!i_reset_n) begin
			pc <= RESET_PC;
		end else if (i_valid) begin
			pc <= next_pc;
		end
	end

	always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
		if (!i_reset_n) begin
			status_flags_reg <= RESET_FLAGS;
		end else if (is_cmpi) begin
			status_flags_reg <= next_flags;
		end
	end

	// Return address is offered in the same cycle the counter jumps.
	always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
		if (!i_reset_n) begin
			push_valid <= 1'b0;
			push_addr <= RESET_PC;
		end else begin
			push_valid <= is_ptr;
			push_addr <= return_pc;
		end
	end

	assign o_pc = pc;
	assign o_status_flags_reg = status_flags_reg;
	assign o_push_valid = push_valid;
	assign o_push_addr = push_addr;

	// The call has two steps: issue, then jump with the return address.
	sequence s_call_issue;
		is_ptr;
	endsequence

	sequence s_call_result;
		(pc == $past(i_pointer)) && push_valid
			&& (push_addr == $past(pc) + STEP_ONE);
	endsequence

	property p_ptr_call;
		@(posedge i_clk_sys) disable iff (!i_reset_n)
		s_call_issue |=> s_call_result;
	endproperty
	a_ptr_call: assert property (p_ptr_call)
		else $error("pointer call target wrong");

	property p_compare_skip_equal;
		@(posedge i_clk_sys) disable iff (!i_reset_n)
		(i_valid && i_op == OP_COMPARE_SKIP_EQ
			&& i_dest_value == i_source_register && !i_next_two_word)
		|=> pc == $past(pc) + SKIP_ONE_WORD;
	endproperty
	a_compare_skip_equal: assert property (p_compare_skip_equal)
		else $error("compare skip did not skip");

	property p_cmpi;
		@(posedge i_clk_sys) disable iff (!i_reset_n)
		is_cmpi |=> status_flags_reg[FLAG_Z]
			== ($past(i_dest_value) == $past(i_immediate));
	endproperty
	a_cmpi: assert property (p_cmpi)
		else $error("compare zero flag wrong");

	property p_skip_reg_bit_clear;
		@(posedge i_clk_sys) disable iff (!i_reset_n)
		(i_valid && i_op == OP_SKIP_REG_BIT_CLR && i_next_two_word
			&& !i_source_register[i_bit_sel])
		|=> pc == $past(pc) + SKIP_TWO_WORD;
	endproperty
	a_skip_reg_bit_clear: assert property (p_skip_reg_bit_clear)
		else $error("register bit skip wrong");

	property p_skip_io_bit_set;
		@(posedge i_clk_sys) disable iff (!i_reset_n)
		(i_valid && i_op == OP_SKIP_IO_BIT_SET && !i_io_data[i_bit_sel])
		|=> pc == $past(pc) + STEP_ONE;
	endproperty
	a_skip_io_bit_set: assert property (p_skip_io_bit_set)
		else $error("io bit set skip wrong");

	property p_skip_io_bit_clear;
		@(posedge i_clk_sys) disable iff (!i_reset_n)
		(i_valid && i_op == OP_SKIP_IO_BIT_CLR)
		|=> $stable(status_flags_reg);
	endproperty
	a_skip_io_bit_clear: assert property (p_skip_io_bit_clear)
		else $error("io bit clear changed flags");

	property p_branch_flag_set;
		@(posedge i_clk_sys) disable iff (!i_reset_n)
		(i_valid && i_op == OP_BRANCH_FLAG_SET && sel_flag)
		|=> pc == $past(pc) + {{9{$past(i_offset[6])}},
			$past(i_offset)} + STEP_ONE;
	endproperty
	a_branch_flag_set: assert property (p_branch_flag_set)
		else $error("branch on set target wrong");

	property p_branch_flag_clear;
		@(posedge i_clk_sys) disable iff (!i_reset_n)
		(i_valid && i_op == OP_BRANCH_FLAG_CLR && sel_flag)
		|=> (pc == $past(pc) + STEP_ONE) && $stable(status_flags_reg);
	endproperty
	a_branch_flag_clear: assert property (p_branch_flag_clear)
		else $error("branch on clear not fall through");

	property p_signed;
		@(posedge i_clk_sys) disable iff (!i_reset_n)
		(is_branch && i_offset == 7'h7f) |=> pc == $past(pc);
	endproperty
	a_signed: assert property (p_signed)
		else $error("offset not signed");
endmodule : branch_skip_compare_exec

// >>> rtl/pc_next_calc.sv
// Next program counter and return address arithmetic.
module pc_next_calc
	import flow_exec_pkg::*;
(
	// Current state
	input  wire logic [15:0] i_pc,
	// Choice of target
	input  wire logic        i_take_ptr,
	input  wire logic [15:0] i_ptr,
	input  wire logic        i_take_branch,
	input  wire logic [6:0]  i_offset,
	input  wire logic        i_skip,
	input  wire logic        i_next_two_word,
	// Results
	output logic      [15:0] o_next_pc,
	output logic      [15:0] o_return_pc
);
	wire logic [15:0] offset_ext;
	wire logic [15:0] skip_step;

	// The offset is signed, so backward branches wrap correctly.
	assign offset_ext = {{9{i_offset[6]}}, i_offset};
	assign skip_step = i_next_two_word ? SKIP_TWO_WORD
		: SKIP_ONE_WORD;
	assign o_return_pc = i_pc + STEP_ONE;
	assign o_next_pc = i_take_ptr ? i_ptr
		: i_take_branch ? i_pc + offset_ext + STEP_ONE
		: i_skip ? i_pc + skip_step
		: i_pc + STEP_ONE;
endmodule : pc_next_calc
